// ===== verilog/uhb_host_if.sv
// Processor-side read/write logic of the serial controller with its
// general-purpose modem ports. Assumes the serial core sits on CLK.
//
// Contract
// - Deselected: bus floats, strobes ignored.
// - No transfer without chip select low.
// - Control/data select: high control, low data.
// - Data read drives received character.
// - Data write captures character to transmit.
// - Control read drives status word.
// - Control write accepts a command word.
// - Inverting input port visible in status.
// - Command bit drives first output low.
// - Flag transmit room and waiting character.
// - Status readable any time, errors included.
// - Data write leading edge clears transmit ready.
// - Second command bit drives output low.
`default_nettype none
`include "uhb_defs.svh"

module uhb_host_if (
	input  wire logic       CLK,
	input  wire logic       RESET,
	input  wire logic       CS_N,
	input  wire logic       RD_N,
	input  wire logic       WR_N,
	input  wire logic       CD,
	input  wire logic [7:0] DATA_IN,
	output logic      [7:0] DATA_OUT,
	output logic            DATA_OE,
	input  wire logic       DSR_N,
	output logic            DTR_N,
	output logic            RTS_N,
	output logic            XMIT_READY,
	output logic            RECV_READY,
	output logic      [7:0] TX_DATA,
	output logic            TX_VALID,
	input  wire logic       TX_TAKE,
	input  wire logic       TX_EMPTY,
	input  wire logic [7:0] RX_DATA,
	input  wire logic       RX_VALID,
	input  wire logic       PARITY_ERR,
	input  wire logic       FRAME_ERR,
	input  wire logic       SYNC_DET,
	output logic      [7:0] CMD_WORD,
	output logic            CMD_STROBE
);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [`UHB_SYNC_W-1:0] sync_q;
	logic                   cs_n_s;
	logic                   rd_n_s;
	logic                   wr_n_s;
	logic                   cd_s;
	logic                   dsr_n_s;
	logic [7:0]             din_s;

	uhb_sync u_sync (
		.clk      (CLK),
		.reset    (RESET),
		.async_in ({DSR_N, CS_N, RD_N, WR_N, CD, DATA_IN}),
		.sync_out (sync_q)
	);

	assign dsr_n_s = sync_q[12];
	assign cs_n_s  = sync_q[11];
	assign rd_n_s  = sync_q[10];
	assign wr_n_s  = sync_q[9];
	assign cd_s    = sync_q[8];
	assign din_s   = sync_q[7:0];

	// ****************************************************************
	// Access tracking
	// ****************************************************************
	uhb_pkg::uhb_acc_type acc_r;
	uhb_pkg::uhb_acc_type acc_nxt;
	logic                 acc_cd_r;
	logic                 acc_cd_nxt;
	logic                 wr_lead;
	logic                 wr_done;
	logic                 rd_done;

	// Both strobes low together is not a legal cycle and starts nothing
	always_comb begin
		acc_nxt    = acc_r;
		acc_cd_nxt = acc_cd_r;
		wr_lead    = 1'b0;
		wr_done    = 1'b0;
		rd_done    = 1'b0;
		unique case (acc_r)
			uhb_pkg::UHB_IDLE: begin
				if (uhb_pkg::uhb_sel(cs_n_s, rd_n_s) && wr_n_s) begin
					acc_nxt    = uhb_pkg::UHB_RD;
					acc_cd_nxt = cd_s;
				end else if (uhb_pkg::uhb_sel(cs_n_s, wr_n_s) && rd_n_s) begin
					acc_nxt    = uhb_pkg::UHB_WR;
					acc_cd_nxt = cd_s;
					wr_lead    = 1'b1;
				end
			end
			uhb_pkg::UHB_RD: begin
				if (rd_n_s || cs_n_s) begin
					acc_nxt = uhb_pkg::UHB_IDLE;
					rd_done = 1'b1;
				end
			end
			uhb_pkg::UHB_WR: begin
				// Deselect before the trailing edge drops the write
				if (cs_n_s) begin
					acc_nxt = uhb_pkg::UHB_IDLE;
				end else if (wr_n_s) begin
					acc_nxt = uhb_pkg::UHB_IDLE;
					wr_done = 1'b1;
				end
			end
			default: begin
				acc_nxt = uhb_pkg::UHB_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			acc_r    <= uhb_pkg::UHB_IDLE;
			acc_cd_r <= 1'b0;
		end else begin
			acc_r    <= acc_nxt;
			acc_cd_r <= acc_cd_nxt;
		end
	end

	// ****************************************************************
	// Command word and modem outputs
	// ****************************************************************
	logic [7:0] cmd_r;
	logic       cmd_wr;

	assign cmd_wr = wr_done && acc_cd_r;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			cmd_r      <= `UHB_CMD_RESET;
			CMD_STROBE <= 1'b0;
		end else begin
			CMD_STROBE <= cmd_wr;
			if (cmd_wr)
				cmd_r <= din_s;
		end
	end

	assign CMD_WORD = cmd_r;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			DTR_N <= 1'b1;
			RTS_N <= 1'b1;
		end else begin
			DTR_N <= !cmd_r[`UHB_CMD_DTR];
			RTS_N <= !cmd_r[`UHB_CMD_RTS];
		end
	end

	// ****************************************************************
	// Transmit path
	// ****************************************************************
	logic xmit_ready_r;

	always_ff @(posedge CLK) begin
		if (RESET) begin
			TX_DATA  <= 8'h00;
			TX_VALID <= 1'b0;
		end else begin
			TX_VALID <= wr_done && !acc_cd_r;
			if (wr_done && !acc_cd_r)
				TX_DATA <= din_s;
		end
	end

	// Cleared at the strobe's leading edge; the core's take wins
	always_ff @(posedge CLK) begin
		if (RESET)
			xmit_ready_r <= 1'b1;
		else if (TX_TAKE)
			xmit_ready_r <= 1'b1;
		else if (wr_lead && !cd_s)
			xmit_ready_r <= 1'b0;
	end

	// ****************************************************************
	// Receive path
	// ****************************************************************
	logic [7:0] rx_hold_r;
	logic       recv_ready_r;
	logic       overrun_r;
	logic       data_rd_active;

	assign data_rd_active = (acc_r == uhb_pkg::UHB_RD) && !acc_cd_r;

	always_ff @(posedge CLK) begin
		if (RESET)
			rx_hold_r <= 8'h00;
		else if (RX_VALID)
			rx_hold_r <= RX_DATA;
	end

	// A new character beats the read that would clear the flag
	always_ff @(posedge CLK) begin
		if (RESET)
			recv_ready_r <= 1'b0;
		else if (!cmd_r[`UHB_CMD_RX_EN])
			recv_ready_r <= 1'b0;
		else if (RX_VALID)
			recv_ready_r <= 1'b1;
		else if (rd_done && !acc_cd_r)
			recv_ready_r <= 1'b0;
	end

	// Overrun also when a character lands during a data read
	always_ff @(posedge CLK) begin
		if (RESET)
			overrun_r <= 1'b0;
		else if (RX_VALID && (recv_ready_r || data_rd_active))
			overrun_r <= 1'b1;
		else if (cmd_wr && din_s[`UHB_CMD_ERR_RST])
			overrun_r <= 1'b0;
	end

	// ****************************************************************
	// Status and ready pins
	// ****************************************************************
	logic [7:0] status;

	always_comb begin
		status                      = 8'h00;
		status[`UHB_ST_XMIT_READY]  = xmit_ready_r;
		status[`UHB_ST_RECV_READY]  = recv_ready_r;
		status[`UHB_ST_TX_EMPTY]    = TX_EMPTY;
		status[`UHB_ST_PARITY]      = PARITY_ERR;
		status[`UHB_ST_OVERRUN]     = overrun_r;
		status[`UHB_ST_FRAMING]     = FRAME_ERR;
		status[`UHB_ST_SYNC_DET]    = SYNC_DET;
		status[`UHB_ST_DSR]         = !dsr_n_s;
	end

	// Pin is masked by transmit enable, the status bit is not
	always_ff @(posedge CLK) begin
		if (RESET) begin
			XMIT_READY <= 1'b0;
			RECV_READY <= 1'b0;
		end else begin
			XMIT_READY <= xmit_ready_r && cmd_r[`UHB_CMD_TX_EN];
			RECV_READY <= recv_ready_r;
		end
	end

	// ****************************************************************
	// Data bus drive
	// ****************************************************************
	// Drive only for a selected read; otherwise float
	always_ff @(posedge CLK) begin
		if (RESET) begin
			DATA_OE  <= 1'b0;
			DATA_OUT <= 8'h00;
		end else if (acc_nxt == uhb_pkg::UHB_RD) begin
			DATA_OE  <= 1'b1;
			DATA_OUT <= acc_cd_nxt ? status : rx_hold_r;
		end else begin
			DATA_OE  <= 1'b0;
			DATA_OUT <= 8'h00;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);

	property p_float_deselected;
		cs_n_s |=> !DATA_OE;
	endproperty
	a_float_deselected: assert property (p_float_deselected)
		else $error("bus driven while deselected");

	property p_write_needs_select;
		TX_VALID |-> $past(acc_r == uhb_pkg::UHB_WR && !cs_n_s && !acc_cd_r);
	endproperty
	a_write_needs_select: assert property (p_write_needs_select)
		else $error("character write without selected data write");

	property p_cmd_path;
		CMD_STROBE |-> $past(acc_cd_r && acc_r == uhb_pkg::UHB_WR)
			##0 CMD_WORD == $past(din_s);
	endproperty
	a_cmd_path: assert property (p_cmd_path)
		else $error("command word not taken from control write");

	property p_data_read;
		(acc_nxt == uhb_pkg::UHB_RD && !acc_cd_nxt)
			|=> DATA_OE && DATA_OUT == $past(rx_hold_r);
	endproperty
	a_data_read: assert property (p_data_read)
		else $error("data read does not show received character");

	property p_status_read;
		(acc_nxt == uhb_pkg::UHB_RD && acc_cd_nxt)
			|=> DATA_OE && DATA_OUT[`UHB_ST_DSR] == !$past(dsr_n_s)
			&& DATA_OUT[`UHB_ST_OVERRUN] == $past(overrun_r);
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("status read shows wrong status");

	property p_dtr;
		cmd_r[`UHB_CMD_DTR] |=> !DTR_N;
	endproperty
	a_dtr: assert property (p_dtr)
		else $error("first modem output not low");

	property p_rts;
		!cmd_r[`UHB_CMD_RTS] |=> RTS_N;
	endproperty
	a_rts: assert property (p_rts)
		else $error("second modem output low without command bit");

	property p_xmit_clear;
		(wr_lead && !cd_s && !TX_TAKE) |=> !xmit_ready_r ##1 !XMIT_READY;
	endproperty
	a_xmit_clear: assert property (p_xmit_clear)
		else $error("transmit ready not cleared by data write");

	property p_recv_set;
		(RX_VALID && cmd_r[`UHB_CMD_RX_EN]) |=> recv_ready_r ##1 RECV_READY;
	endproperty
	a_recv_set: assert property (p_recv_set)
		else $error("receive ready not raised by new character");

	property p_float_idle;
		(!cs_n_s && rd_n_s && acc_r == uhb_pkg::UHB_IDLE) |=> !DATA_OE;
	endproperty
	a_float_idle: assert property (p_float_idle)
		else $error("bus driven with no read strobe");

	property p_sync_delay;
		$rose(DATA_OE) |-> !$past(RD_N, 3) && !$past(CS_N, 3);
	endproperty
	a_sync_delay: assert property (p_sync_delay)
		else $error("bus driven earlier than synchronised strobes");

	c_data_write: cover property (TX_VALID);
	c_cmd_write: cover property (CMD_STROBE);
	c_status_read: cover property (DATA_OE && acc_cd_r);
	c_overrun: cover property ($rose(overrun_r));

endmodule

`default_nettype wire

// ===== verilog/uhb_defs.svh
// Constants of the host bus interface: timing, command and status bits.
// Included by the interface and synchroniser design files, not the package; defines only.
`ifndef UHB_DEFS_SVH
`define UHB_DEFS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define UHB_CLK_PERIOD_NS    5
`define UHB_CLK_HZ           200000000
// Least ratio of system clock to the faster serial bit rate
`define UHB_CLK_PER_BIT_MIN  30
`define UHB_MAX_BIT_RATE     (`UHB_CLK_HZ / `UHB_CLK_PER_BIT_MIN)

// ****************************************************************
// Synchroniser widths
// ****************************************************************
`define UHB_DATA_W           8
`define UHB_SYNC_W           13

// ****************************************************************
// Command word bit positions and reset value
// ****************************************************************
`define UHB_CMD_TX_EN        0
`define UHB_CMD_DTR          1
`define UHB_CMD_RX_EN        2
`define UHB_CMD_ERR_RST      4
`define UHB_CMD_RTS          5
`define UHB_CMD_RESET        8'h00

// ****************************************************************
// Status word bit positions
// ****************************************************************
`define UHB_ST_XMIT_READY    0
`define UHB_ST_RECV_READY    1
`define UHB_ST_TX_EMPTY      2
`define UHB_ST_PARITY        3
`define UHB_ST_OVERRUN       4
`define UHB_ST_FRAMING       5
`define UHB_ST_SYNC_DET      6
`define UHB_ST_DSR           7

`endif

// ===== verilog/uhb_pkg.sv
// Types shared by the host bus interface design files.
// Assumes nothing of its surroundings.
`default_nettype none

package uhb_pkg;

	// Bus access in progress, as seen after synchronisation
	typedef enum logic [1:0] {
		UHB_IDLE,
		UHB_RD,
		UHB_WR
	} uhb_acc_type;

	// Selected and strobe asserted, both active low
	function automatic logic uhb_sel(input logic cs_n, input logic strb_n);
		return !cs_n && !strb_n;
	endfunction

endpackage

`default_nettype wire

// ===== verilog/uhb_sync.sv
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes each bit is a slow level; no word coherence is promised.
`default_nettype none
`include "uhb_defs.svh"

module uhb_sync (
	input  wire logic                   clk,
	input  wire logic                   reset,
	input  wire logic [`UHB_SYNC_W-1:0] async_in,
	output logic      [`UHB_SYNC_W-1:0] sync_out
);

	// Meta stage is read only by the second stage
	logic [`UHB_SYNC_W-1:0] meta_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			meta_r   <= '1;
			sync_out <= '1;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

`default_nettype wire

// ===== tb/uhb_host_model.sv
// Host processor model driving the parallel bus of the interface.
// Assumes the bench clock on clk; pins change by NBA after an edge.
`default_nettype none

module uhb_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe,
	output logic            cs_n,
	output logic            rd_n,
	output logic            wr_n,
	output logic            cd,
	output logic      [7:0] data_in
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		cd = 1'b0;
		data_in = 8'h00;
	end

	task automatic drive(input logic c, r, w, s, input logic [7:0] d);
		@(posedge clk);
		cs_n <= c;
		rd_n <= r;
		wr_n <= w;
		cd <= s;
		data_in <= d;
	endtask

	// Chip select kept low until the trailing edge has been taken
	task automatic write(input logic s, input logic [7:0] d);
		drive(1'b0, 1'b1, 1'b0, s, d);
		repeat (4) @(posedge clk);
		drive(1'b0, 1'b1, 1'b1, s, d);
		repeat (5) @(posedge clk);
		// Released bus shows the inverse, not a stale copy
		drive(1'b1, 1'b1, 1'b1, s, ~d);
		repeat (3) @(posedge clk);
	endtask

	task automatic read(input logic s, output logic [7:0] q);
		int n;
		n = 0;
		drive(1'b0, 1'b0, 1'b1, s, data_in);
		do begin
			@(posedge clk);
			n++;
		end while (data_oe !== 1'b1 && n < 12);
		q = data_out;
		repeat (3) @(posedge clk);
		drive(1'b0, 1'b1, 1'b1, s, data_in);
		repeat (4) @(posedge clk);
		drive(1'b1, 1'b1, 1'b1, s, data_in);
		repeat (3) @(posedge clk);
	endtask
endmodule

`default_nettype wire

// ===== tb/tb_usart_host_bus_interface.sv
// Self-checking bench of the host bus interface with a host model.
// Assumes the serial core side is played by the bench itself.
`default_nettype none

module tb_usart_host_bus_interface;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk = 1'b0;
	logic       reset = 1'b1;
	logic       cs_n, rd_n, wr_n, cd;
	logic [7:0] data_in, data_out, tx_data, rx_data, cmd_word, q;
	logic       data_oe, dsr_n, dtr_n, rts_n, xmit_ready, recv_ready;
	logic       tx_valid, tx_take, tx_empty, rx_valid;
	logic       parity_err, frame_err, sync_det, cmd_strobe;
	int         err_total = 0;
	int         num_checks = 0;
	int         tx_cnt = 0;
	int         cmd_cnt = 0;
	int         n;

	// ****************************************************************
	// Clock, instances and pulse counters
	// ****************************************************************
	always #2.5 clk = ~clk;

	uhb_host_if dut (.CLK(clk), .RESET(reset), .CS_N(cs_n), .RD_N(rd_n),
		.WR_N(wr_n), .CD(cd), .DATA_IN(data_in), .DATA_OUT(data_out),
		.DATA_OE(data_oe), .DSR_N(dsr_n), .DTR_N(dtr_n), .RTS_N(rts_n),
		.XMIT_READY(xmit_ready), .RECV_READY(recv_ready),
		.TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_TAKE(tx_take),
		.TX_EMPTY(tx_empty), .RX_DATA(rx_data), .RX_VALID(rx_valid),
		.PARITY_ERR(parity_err), .FRAME_ERR(frame_err),
		.SYNC_DET(sync_det), .CMD_WORD(cmd_word),
		.CMD_STROBE(cmd_strobe));

	uhb_host_model host (.clk(clk), .data_out(data_out),
		.data_oe(data_oe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
		.cd(cd), .data_in(data_in));

	always @(posedge clk) begin
		if (tx_valid === 1'b1)
			tx_cnt <= tx_cnt + 1;
		if (cmd_strobe === 1'b1)
			cmd_cnt <= cmd_cnt + 1;
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic chk(input logic [7:0] got, exp, input string m);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s got %h", $time, m, got);
		end
	endtask

	task automatic core_char(input logic [7:0] c);
		@(posedge clk);
		rx_data <= c;
		rx_valid <= 1'b1;
		@(posedge clk);
		rx_valid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic do_cmd(input logic [7:0] w);
		n = cmd_cnt;
		host.write(1'b1, w);
		chk(8'(cmd_cnt - n), 8'h01, "cmd strobe");
		chk(cmd_word, w, "cmd word");
		chk(dtr_n, !w[1], "dtr level");
		chk(rts_n, !w[5], "rts level");
		chk(xmit_ready, w[0], "tx ready mask");
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset;
		chk(dtr_n, 1'b1, "dtr reset");
		chk(rts_n, 1'b1, "rts reset");
		chk(data_oe, 1'b0, "bus driven");
		chk(cmd_word, 8'h00, "cmd reset");
		$display("t_reset done");
	endtask

	task automatic t_cmd;
		do_cmd(8'h04);
		do_cmd(8'h27);
		chk(8'(tx_cnt), 8'h00, "data path hit");
		$display("t_cmd done");
	endtask

	// Ready must drop while the strobe is still low
	task automatic t_txw;
		n = tx_cnt;
		host.drive(1'b0, 1'b1, 1'b0, 1'b0, 8'hA5);
		repeat (6) @(posedge clk);
		chk(xmit_ready, 1'b0, "ready at lead");
		chk(8'(tx_cnt - n), 8'h00, "early take");
		host.drive(1'b0, 1'b1, 1'b1, 1'b0, 8'hA5);
		repeat (6) @(posedge clk);
		chk(8'(tx_cnt - n), 8'h01, "tx pulse");
		chk(tx_data, 8'hA5, "tx data");
		chk(8'(cmd_cnt), 8'h02, "ctrl path hit");
		host.drive(1'b1, 1'b1, 1'b1, 1'b0, 8'h5A);
		@(posedge clk);
		tx_take <= 1'b1;
		@(posedge clk);
		tx_take <= 1'b0;
		repeat (3) @(posedge clk);
		chk(xmit_ready, 1'b1, "ready back");
		$display("t_txw done");
	endtask

	task automatic t_rxr;
		core_char(8'h3C);
		chk(recv_ready, 1'b1, "rx ready");
		host.read(1'b0, q);
		chk(q, 8'h3C, "rx char");
		repeat (2) @(posedge clk);
		chk(recv_ready, 1'b0, "rx ready clr");
		$display("t_rxr done");
	endtask

	task automatic t_stat;
		dsr_n <= 1'b0;
		tx_empty <= 1'b1;
		parity_err <= 1'b1;
		sync_det <= 1'b1;
		repeat (4) @(posedge clk);
		host.read(1'b1, q);
		chk(q, 8'hCD, "status");
		core_char(8'h11);
		core_char(8'h77);
		frame_err <= 1'b1;
		host.read(1'b1, q);
		chk(q, 8'hFF, "overrun status");
		host.read(1'b0, q);
		chk(q, 8'h77, "newest char");
		// Error reset bit clears overrun; core errors are left alone
		do_cmd(8'h37);
		host.read(1'b1, q);
		chk(q, 8'hED, "overrun cleared");
		$display("t_stat done");
	endtask

	task automatic t_desel;
		n = cmd_cnt;
		host.drive(1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
		repeat (6) @(posedge clk);
		chk(data_oe, 1'b0, "read unselected");
		host.drive(1'b1, 1'b1, 1'b0, 1'b1, 8'hFF);
		repeat (5) @(posedge clk);
		host.drive(1'b1, 1'b1, 1'b1, 1'b1, 8'h00);
		repeat (6) @(posedge clk);
		chk(8'(cmd_cnt - n), 8'h00, "write unselected");
		chk(cmd_word, 8'h37, "cmd kept");
		host.drive(1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
		repeat (6) @(posedge clk);
		chk(data_oe, 1'b0, "no strobe");
		host.drive(1'b1, 1'b1, 1'b1, 1'b0, 8'h00);
		$display("t_desel done");
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		dsr_n = 1'b1;
		tx_take = 1'b0;
		tx_empty = 1'b0;
		rx_data = 8'h00;
		rx_valid = 1'b0;
		parity_err = 1'b0;
		frame_err = 1'b0;
		sync_det = 1'b0;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
		t_reset();
		t_cmd();
		t_txw();
		t_rxr();
		t_stat();
		t_desel();
		finish_test();
	end

	// Tests need well under a thousand cycles
	initial begin
		repeat (4000) @(posedge clk);
		err_total++;
		finish_test();
	end
endmodule

`default_nettype wire
